//--- hdl/fsm_consts.vh
`ifndef FSM_CONSTS_VH
`define FSM_CONSTS_VH
// ==========================================
// register byte offsets
`define FSM_A_CTRL 12'h000
`define FSM_A_ADDR 12'h004
`define FSM_A_LSEL 12'h008
`define FSM_A_LCFG 12'h00C
`define FSM_A_LLOC 12'h010
`define FSM_A_GO 12'h014
`define FSM_A_STAT 12'h018
`define FSM_A_DBIX 12'h01C
`define FSM_A_DBDT 12'h020
`define FSM_A_IBIX 12'h024
`define FSM_A_IBDT 12'h028
`define FSM_A_OBIX 12'h02C
`define FSM_A_OBDT 12'h030
// ==========================================
// field positions and values
`define FSM_ADDR_MIN 7'h01
`define FSM_ADDR_MAX 7'h7E
`define FSM_ADDR_DFLT 7'h7E
`define FSM_MODE_BIT 2'h0
`define FSM_MODE_BYTE 2'h1
`define FSM_MODE_WORD 2'h2
`define FSM_ONES16 16'hFFFF
`define FSM_ZERO16 16'h0000
`define FSM_HTRANS_NSEQ 1
`define FSM_GO_BIT 0
`endif

//--- hdl/fsm_byte_ram.v
`timescale 1ns/10ps
// ==========================================
// byte buffer, flip-flops addressed by index, two ports
module fsm_byte_ram #(
	parameter DEPTH = 244,
	parameter AW = 8
) (
	input wire mclk,
	input wire srst,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [7:0] wdata,
	input wire [AW-1:0] raddr_a,
	output wire [7:0] rdata_a,
	input wire [AW-1:0] raddr_b,
	output wire [7:0] rdata_b
);
	reg [7:0] mem_q [0:DEPTH-1];
	integer i;
	// synchronous clear and write
	always @(posedge mclk) begin
		if (srst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= 8'h00;
			end
		end else if (we && waddr < DEPTH) begin
			mem_q[waddr] <= wdata;
		end
	end
	// out-of-range index reads zero
	assign rdata_a = (raddr_a < DEPTH) ? mem_q[raddr_a] : 8'h00;
	assign rdata_b = (raddr_b < DEPTH) ? mem_q[raddr_b] : 8'h00;
endmodule

//--- hdl/fsm_link_mapper.v
`timescale 1ns/10ps
`include "fsm_consts.vh"
// Behaviour
// - slave address limited to 1..126
// - rotary off: use stored address
// - rotary on: sample switch once, on the first cycle it is enabled after reset
// - buffer: 244 input plus 244 output bytes
// - read link: output bytes to database
// - write link: database to input bytes
// - input and output bytes separately indexed
// - four links with start, count, location
// - bit read stores FFFF or 0000
// - bit write reduces word to 0/1
// - bit offset from LSB, ascending
// - byte read into upper eight bits
// - byte write takes upper eight bits
// - word write high byte at lower index
// - word read pairs bytes into words
// - optional status word into database
module fsm_link_mapper #(
	parameter NLINK = 4,
	parameter DBN = 256,
	parameter NBYTE = 244,
	parameter TOTAL_BYTES = 416
) (
	input wire mclk,
	input wire srst,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hsel,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [6:0] rotary_sw,
	input wire fb_wr,
	input wire [7:0] fb_waddr,
	input wire [7:0] fb_wdata,
	input wire [7:0] fb_raddr,
	output reg [7:0] fb_rdata,
	input wire [15:0] fb_module_status,
	output reg [6:0] slave_addr,
	output reg busy
);
	// ==========================================
	// helpers
	function [6:0] clamp_addr;
		input [6:0] a;
		begin
			if (a < `FSM_ADDR_MIN || a > `FSM_ADDR_MAX)
				clamp_addr = `FSM_ADDR_DFLT;
			else
				clamp_addr = a;
		end
	endfunction
	function word_to_bit;
		input [15:0] w;
		begin
			word_to_bit = |w;
		end
	endfunction
	// ==========================================
	// bus slave
	reg ph_q, ph_wr_q;
	reg [11:0] ph_a_q;
	reg rot_en_q, started_q;
	reg [6:0] cfg_addr_q;
	reg [1:0] lsel_q;
	reg [15:0] l_start_q [0:NLINK-1];
	reg [15:0] l_count_q [0:NLINK-1];
	reg [1:0] l_mode_q [0:NLINK-1];
	reg l_wr_q [0:NLINK-1];
	reg l_sten_q [0:NLINK-1];
	reg [7:0] l_loc_q [0:NLINK-1];
	reg [2:0] l_off_q [0:NLINK-1];
	reg [15:0] l_stloc_q [0:NLINK-1];
	reg [15:0] db_q [0:DBN-1];
	reg [15:0] dbix_q;
	reg [7:0] ibix_q, obix_q;
	wire take = hsel && hready && htrans[`FSM_HTRANS_NSEQ];
	// ==========================================
	// link engine state
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_STAT = 3'b100;
	reg [2:0] st_q;
	reg [1:0] li_q;
	reg [15:0] n_q;
	reg half_q;
	wire [15:0] reg_ix = l_start_q[li_q] + n_q;
	wire [15:0] cur_w = (reg_ix < DBN) ? db_q[reg_ix[7:0]] : `FSM_ZERO16;
	wire [10:0] bitpos = {l_loc_q[li_q], 3'h0} + {8'h00, l_off_q[li_q]} + n_q[10:0];
	reg [7:0] byte_ix;
	always @* begin
		case (l_mode_q[li_q])
			`FSM_MODE_BIT: byte_ix = bitpos[10:3];
			`FSM_MODE_BYTE: byte_ix = l_loc_q[li_q] + n_q[7:0];
			default: byte_ix = l_loc_q[li_q] + {n_q[6:0], half_q};
		endcase
	end
	// separate input and output byte spaces, both from zero
	wire [7:0] ob_eng, ob_bus, ib_eng, ib_bus;
	reg ib_we;
	reg [7:0] ib_wd;
	reg [15:0] wr_hi_q;
	wire ib_we_bus = ph_q && ph_wr_q && ph_a_q == `FSM_A_IBDT;
	fsm_byte_ram #(.DEPTH(NBYTE), .AW(8)) u_out (
		.mclk(mclk), .srst(srst), .we(fb_wr), .waddr(fb_waddr), .wdata(fb_wdata),
		.raddr_a(byte_ix), .rdata_a(ob_eng), .raddr_b(obix_q), .rdata_b(ob_bus)
	);
	fsm_byte_ram #(.DEPTH(NBYTE), .AW(8)) u_in (
		.mclk(mclk), .srst(srst), .we(ib_we | ib_we_bus),
		.waddr(ib_we ? byte_ix : ibix_q), .wdata(ib_we ? ib_wd : hwdata[7:0]),
		.raddr_a(byte_ix), .rdata_a(ib_eng), .raddr_b(fb_raddr), .rdata_b(ib_bus)
	);
	// write-link byte value per mode
	always @* begin
		ib_we = st_q == ST_RUN && l_wr_q[li_q] && l_count_q[li_q] != 16'h0000;
		case (l_mode_q[li_q])
			`FSM_MODE_BIT: begin
				ib_wd = ib_eng;
				ib_wd[bitpos[2:0]] = word_to_bit(cur_w);
			end
			`FSM_MODE_BYTE: ib_wd = cur_w[15:8];
			default: ib_wd = half_q ? cur_w[7:0] : cur_w[15:8];
		endcase
	end
	// ==========================================
	// engine sequencing: cycle through every link
	integer k;
	integer j;
	wire last = (l_mode_q[li_q] == `FSM_MODE_WORD) ? (n_q + 16'h0001 >= l_count_q[li_q] && half_q)
		: (n_q + 16'h0001 >= l_count_q[li_q]);
	wire go_wr = ph_q && ph_wr_q && ph_a_q == `FSM_A_GO && hwdata[`FSM_GO_BIT];
	always @(posedge mclk) begin
		if (srst) begin
			st_q <= ST_IDLE;
			li_q <= 2'h0;
			n_q <= 16'h0000;
			half_q <= 1'b0;
			wr_hi_q <= 16'h0000;
			busy <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (go_wr) begin
						st_q <= ST_RUN;
						li_q <= 2'h0;
						n_q <= 16'h0000;
						half_q <= 1'b0;
						busy <= 1'b1;
					end
				end
				ST_RUN: begin
					if (l_mode_q[li_q] == `FSM_MODE_WORD)
						half_q <= ~half_q;
					if (l_count_q[li_q] == 16'h0000 || last) begin
						st_q <= ST_STAT;
					end else if (l_mode_q[li_q] != `FSM_MODE_WORD || half_q) begin
						n_q <= n_q + 16'h0001;
					end
					if (!half_q)
						wr_hi_q <= {ob_eng, 8'h00};
				end
				ST_STAT: begin
					n_q <= 16'h0000;
					half_q <= 1'b0;
					if (li_q == NLINK - 1) begin
						st_q <= ST_IDLE;
						busy <= 1'b0;
					end else begin
						li_q <= li_q + 2'h1;
						st_q <= ST_RUN;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	// ==========================================
	// database writes: read links, status, bus
	reg db_we;
	reg [15:0] db_wd;
	reg [15:0] db_wa;
	always @* begin
		db_we = 1'b0;
		db_wa = reg_ix;
		db_wd = `FSM_ZERO16;
		if (st_q == ST_RUN && !l_wr_q[li_q] && l_count_q[li_q] != 16'h0000) begin
			case (l_mode_q[li_q])
				`FSM_MODE_BIT: begin
					db_we = 1'b1;
					db_wd = ob_eng[bitpos[2:0]] ? `FSM_ONES16 : `FSM_ZERO16;
				end
				`FSM_MODE_BYTE: begin
					db_we = 1'b1;
					db_wd = {ob_eng, 8'h00};
				end
				default: begin
					db_we = half_q;
					db_wd = {wr_hi_q[15:8], ob_eng};
				end
			endcase
		end else if (st_q == ST_STAT && l_sten_q[li_q]) begin
			db_we = 1'b1;
			db_wa = l_stloc_q[li_q];
			db_wd = fb_module_status;
		end else if (ph_q && ph_wr_q && ph_a_q == `FSM_A_DBDT) begin
			db_we = 1'b1;
			db_wa = dbix_q;
			db_wd = hwdata[15:0];
		end
	end
	always @(posedge mclk) begin
		if (srst) begin
			for (k = 0; k < DBN; k = k + 1)
				db_q[k] <= `FSM_ZERO16;
		end else if (db_we && db_wa < DBN) begin
			db_q[db_wa[7:0]] <= db_wd;
		end
	end
	// ==========================================
	// slave address selection: switch read once, else stored address
	always @(posedge mclk) begin
		if (srst) begin
			started_q <= 1'b0;
			slave_addr <= `FSM_ADDR_DFLT;
		end else if (rot_en_q) begin
			// switch read once, on the first cycle rotary mode is in force
			if (!started_q) begin
				started_q <= 1'b1;
				slave_addr <= clamp_addr(rotary_sw);
			end
		end else begin
			slave_addr <= clamp_addr(cfg_addr_q);
		end
	end
	// master side reads input bytes from zero upward
	always @(posedge mclk) begin
		if (srst)
			fb_rdata <= 8'h00;
		else
			fb_rdata <= ib_bus;
	end
	// ==========================================
	// register writes and read data
	always @(posedge mclk) begin
		if (srst) begin
			ph_q <= 1'b0;
			ph_wr_q <= 1'b0;
			ph_a_q <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			rot_en_q <= 1'b0;
			cfg_addr_q <= `FSM_ADDR_DFLT;
			lsel_q <= 2'h0;
			dbix_q <= 16'h0000;
			ibix_q <= 8'h00;
			obix_q <= 8'h00;
			for (j = 0; j < NLINK; j = j + 1) begin
				l_start_q[j] <= 16'h0000;
				l_count_q[j] <= 16'h0000;
				l_mode_q[j] <= `FSM_MODE_BIT;
				l_wr_q[j] <= 1'b0;
				l_sten_q[j] <= 1'b0;
				l_loc_q[j] <= 8'h00;
				l_off_q[j] <= 3'h0;
				l_stloc_q[j] <= 16'h0000;
			end
		end else begin
			ph_q <= take;
			ph_wr_q <= hwrite;
			ph_a_q <= haddr[11:0];
			if (take && !hwrite) begin
				case (haddr[11:0])
					`FSM_A_CTRL: hrdata <= {31'h00000000, rot_en_q};
					`FSM_A_ADDR: hrdata <= {25'h0000000, cfg_addr_q};
					`FSM_A_LSEL: hrdata <= {30'h00000000, lsel_q};
					`FSM_A_LCFG: hrdata <= {l_count_q[lsel_q], l_start_q[lsel_q]};
					`FSM_A_LLOC: hrdata <= {l_stloc_q[lsel_q], l_sten_q[lsel_q], l_wr_q[lsel_q],
						l_mode_q[lsel_q], l_off_q[lsel_q], 1'b0, l_loc_q[lsel_q]};
					`FSM_A_STAT: hrdata <= {24'h000000, busy, slave_addr};
					`FSM_A_DBIX: hrdata <= {16'h0000, dbix_q};
					`FSM_A_DBDT: hrdata <= {16'h0000, cur_dbv(dbix_q)};
					`FSM_A_OBDT: hrdata <= {24'h000000, ob_bus};
					default: hrdata <= 32'h00000000;
				endcase
			end
			if (ph_q && ph_wr_q) begin
				case (ph_a_q)
					`FSM_A_CTRL: rot_en_q <= hwdata[0];
					`FSM_A_ADDR: cfg_addr_q <= hwdata[6:0];
					`FSM_A_LSEL: lsel_q <= hwdata[1:0];
					`FSM_A_LCFG: begin
						l_start_q[lsel_q] <= hwdata[15:0];
						l_count_q[lsel_q] <= hwdata[31:16];
					end
					`FSM_A_LLOC: begin
						l_loc_q[lsel_q] <= hwdata[7:0];
						l_off_q[lsel_q] <= hwdata[11:9];
						l_mode_q[lsel_q] <= hwdata[13:12];
						l_wr_q[lsel_q] <= hwdata[14];
						l_sten_q[lsel_q] <= hwdata[15];
						l_stloc_q[lsel_q] <= hwdata[31:16];
					end
					`FSM_A_DBIX: dbix_q <= hwdata[15:0];
					`FSM_A_IBIX: ibix_q <= hwdata[7:0];
					`FSM_A_OBIX: obix_q <= hwdata[7:0];
					default: ;
				endcase
			end
		end
	end
	function [15:0] cur_dbv;
		input [15:0] ix;
		begin
			cur_dbv = (ix < DBN) ? db_q[ix[7:0]] : `FSM_ZERO16;
		end
	endfunction
endmodule

//--- dv/fsm_chk_asserts.sv
`timescale 1ns/10ps
// ==========================================
// port checker for the link mapper
module fsm_chk (
	input wire mclk,
	input wire srst,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hsel,
	input wire hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire fb_wr,
	input wire [7:0] fb_raddr,
	input wire [7:0] fb_rdata,
	input wire [6:0] slave_addr,
	input wire busy
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (srst);
	// accepted address phase
	wire ap = hsel && hready && htrans[1];
	sequence s_go;
		ap && hwrite && haddr[11:0] == 12'h014 && !busy ##1 hwdata[0];
	endsequence
	sequence s_stat;
		ap && !hwrite && haddr[11:0] == 12'h018;
	endsequence
	property p_go;
		s_go |-> ##[0:2] busy;
	endproperty
	a_go: assert property (p_go) else $error("engine did not start");
	property p_range;
		slave_addr >= 7'h01 && slave_addr <= 7'h7E;
	endproperty
	a_range: assert property (p_range) else $error("slave address out of range");
	property p_rst;
		$fell(srst) |-> slave_addr == 7'h7E && !busy && fb_rdata == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("bad values after reset");
	property p_stat;
		s_stat |=> hrdata[7:0] == {$past(busy), $past(slave_addr)};
	endproperty
	a_stat: assert property (p_stat) else $error("status read mismatch");
	property p_unmap;
		ap && !hwrite && haddr[11:0] > 12'h030 |=> hrdata == 32'h00000000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready okay");
	property p_sep;
		fb_wr && !busy && !$past(hsel) ##1 $stable(fb_raddr) && !busy |=> $stable(fb_rdata);
	endproperty
	a_sep: assert property (p_sep) else $error("output write seen in input bytes");
	property p_hold;
		!hsel && !$past(hsel) && !$past(hsel, 2) && !$past(hsel, 3) && !$past(srst)
			&& !$past(srst, 2) |-> $stable(slave_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("slave address moved");
endmodule
bind fsm_link_mapper fsm_chk u_chk (.mclk(mclk), .srst(srst), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsel(hsel), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .fb_wr(fb_wr), .fb_raddr(fb_raddr),
	.fb_rdata(fb_rdata), .slave_addr(slave_addr), .busy(busy));

//--- dv/fsm_fb_master.sv
`timescale 1ns/10ps
// ==========================================
// fieldbus master model
module fsm_fb_master #(
	parameter GAP = 1
) (
	input wire mclk,
	output logic fb_wr,
	output logic [7:0] fb_waddr,
	output logic [7:0] fb_wdata,
	output logic [7:0] fb_raddr,
	input wire [7:0] fb_rdata
);
	logic [7:0] ob [0:15];
	logic [7:0] ib [0:15];
	initial begin
		fb_wr = 1'b0;
		fb_waddr = 8'h00;
		fb_wdata = 8'h00;
		fb_raddr = 8'h00;
	end
	// frames always run from byte zero upward
	task send(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			fb_wr <= 1'b1;
			fb_waddr <= i[7:0];
			fb_wdata <= ob[i];
			@(posedge mclk);
			fb_wr <= 1'b0;
			fb_wdata <= ~ob[i];
			repeat (GAP) @(posedge mclk);
		end
	endtask
	// registered answer, taken two edges on
	task recv(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			fb_raddr <= i[7:0];
			repeat (2) @(posedge mclk);
			ib[i] = fb_rdata;
		end
	endtask
endmodule

//--- dv/fsm_tb.sv
`timescale 1ns/10ps
`include "fsm_consts.vh"
// ==========================================
// bench top
module tb;
	logic mclk, srst, hwrite, hsel;
	logic [31:0] haddr, hwdata, rd;
	logic [1:0] htrans;
	logic [6:0] rotary_sw;
	wire [31:0] hrdata;
	wire hreadyout, hready, fb_wr, busy;
	wire [7:0] fb_waddr, fb_wdata, fb_raddr, fb_rdata;
	wire [6:0] slave_addr;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0;
	logic [15:0] dv [0:7] = '{16'hA1B2, 16'h0C0D, 16'h0100, 16'h0000, 16'h8000, 16'hC3FF,
		16'h7E01, 16'hBEEF};
	logic [7:0] ie [0:8] = '{8'hA1, 8'hB2, 8'h0C, 8'h0D, 8'hA0, 8'hC3, 8'h7E, 8'hBE, 8'hEF};
	int rx [0:6] = '{20, 21, 22, 30, 40, 31, 32};
	logic [15:0] re [0:6] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h5A00, 16'h1234, 16'h1200,
		16'h3400};
	assign hready = hreadyout;
	fsm_link_mapper uut (.mclk(mclk), .srst(srst), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hsel(hsel), .hready(hready), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .rotary_sw(rotary_sw),
		.fb_wr(fb_wr), .fb_waddr(fb_waddr), .fb_wdata(fb_wdata), .fb_raddr(fb_raddr),
		.fb_rdata(fb_rdata), .fb_module_status(16'h5A3C), .slave_addr(slave_addr), .busy(busy));
	fsm_fb_master fbm (.mclk(mclk), .fb_wr(fb_wr), .fb_waddr(fb_waddr), .fb_wdata(fb_wdata),
		.fb_raddr(fb_raddr), .fb_rdata(fb_rdata));
	always #2.5 mclk = ~mclk;
	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task end_of_test;
		$display("checks %0d miscompares %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one single transfer, address phase then data phase
	task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
		ahb(1'b0, a, 32'h00000000);
		chk(nm, rd, exp);
	endtask
	task dbrd(input int ix);
		ahb(1'b1, `FSM_A_DBIX, ix);
		ahb(1'b0, `FSM_A_DBDT, 32'h00000000);
	endtask
	task link(input int i, input logic [15:0] st, input logic [15:0] cn, input logic [7:0] lc,
		input logic [2:0] of, input logic [1:0] md, input logic wr, input logic se,
		input logic [15:0] sr);
		ahb(1'b1, `FSM_A_LSEL, i);
		ahb(1'b1, `FSM_A_LCFG, {cn, st});
		ahb(1'b1, `FSM_A_LLOC, {sr, se, wr, md, of, 1'b0, lc});
	endtask
	task go;
		ahb(1'b1, `FSM_A_GO, 32'h00000001);
		repeat (2) @(posedge mclk);
		while (busy !== 1'b0) @(posedge mclk);
	endtask
	initial begin
		mclk = 1'b0;
		srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		rotary_sw = 7'h05;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		rdchk(`FSM_A_STAT, 32'h0000007E, "stat");
		ahb(1'b1, `FSM_A_ADDR, 32'h00000003);
		ahb(1'b1, `FSM_A_CTRL, 32'h00000000);
		rotary_sw <= 7'h11;
		rdchk(`FSM_A_STAT, 32'h00000003, "stat");
		for (int k = 0; k < 2; k++) begin
			ahb(1'b1, `FSM_A_ADDR, k * 127);
			rdchk(`FSM_A_STAT, 32'h0000007E, "stat");
		end
		ahb(1'b1, `FSM_A_CTRL, 32'h00000001);
		rdchk(`FSM_A_STAT, 32'h00000011, "stat");
		rotary_sw <= 7'h22;
		ahb(1'b1, `FSM_A_ADDR, 32'h00000009);
		rdchk(`FSM_A_STAT, 32'h00000011, "stat");
		rdchk(`FSM_A_CTRL, 32'h00000001, "ctrl");
		ahb(1'b1, `FSM_A_CTRL, 32'h00000000);
		rdchk(`FSM_A_STAT, 32'h00000009, "stat");
		rdchk(12'h040, 32'h00000000, "unmapped");
		$display("test address done");
		for (int k = 0; k < 8; k++) begin
			ahb(1'b1, `FSM_A_DBIX, 10 + k);
			ahb(1'b1, `FSM_A_DBDT, {16'h0000, dv[k]});
		end
		link(0, 10, 2, 0, 0, `FSM_MODE_WORD, 1'b1, 1'b0, 0);
		link(1, 12, 3, 4, 5, `FSM_MODE_BIT, 1'b1, 1'b0, 0);
		link(2, 15, 2, 5, 0, `FSM_MODE_BYTE, 1'b1, 1'b0, 0);
		link(3, 17, 1, 7, 0, `FSM_MODE_WORD, 1'b1, 1'b1, 50);
		go();
		fbm.recv(9);
		for (int k = 0; k < 9; k++)
			chk("in byte", fbm.ib[k], ie[k]);
		dbrd(50);
		chk("status", rd[15:0], 16'h5A3C);
		$display("test write links done");
		fbm.ob[0] = 8'hA4;
		fbm.ob[1] = 8'h5A;
		fbm.ob[2] = 8'h12;
		fbm.ob[3] = 8'h34;
		fbm.send(4);
		link(0, 20, 3, 0, 5, `FSM_MODE_BIT, 1'b0, 1'b0, 0);
		link(1, 30, 1, 1, 0, `FSM_MODE_BYTE, 1'b0, 1'b0, 0);
		link(2, 40, 1, 2, 0, `FSM_MODE_WORD, 1'b0, 1'b0, 0);
		link(3, 31, 2, 2, 0, `FSM_MODE_BYTE, 1'b0, 1'b0, 0);
		rdchk(`FSM_A_LCFG, 32'h0002001F, "link cfg");
		rdchk(`FSM_A_LLOC, 32'h00001002, "link loc");
		go();
		for (int k = 0; k < 7; k++) begin
			dbrd(rx[k]);
			chk("db", rd[15:0], re[k]);
		end
		ahb(1'b1, `FSM_A_OBIX, 32'h00000001);
		rdchk(`FSM_A_OBDT, 32'h0000005A, "out byte");
		ahb(1'b1, `FSM_A_IBIX, 32'h00000002);
		ahb(1'b1, `FSM_A_IBDT, 32'h0000003C);
		fbm.recv(3);
		chk("in byte", fbm.ib[0], 8'hA1);
		chk("in byte", fbm.ib[1], 8'hB2);
		chk("in byte", fbm.ib[2], 8'h3C);
		$display("test read links done");
		end_of_test();
	end
endmodule
